// ---- src/bridge_pcc_pkg.sv ----
package bridge_pcc_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] GEN_CTRL_OFF   = 12'h0D4;
  localparam logic [11:0] CLK_CTRL_OFF   = 12'h0D8;
  localparam logic [11:0] AER_NEXT_NONE  = 12'h000;
  localparam logic [11:0] AER_NEXT_VC    = 12'h150;

  // ****************************************************************
  // General and clock control field positions
  // ****************************************************************
  localparam int          PF_DIS_BIT     = 19;
  localparam int          L0S_LSB        = 16;
  localparam int          L1_LSB         = 13;
  localparam int          VC_EN_BIT      = 12;
  localparam int          CLK_STOP_BIT   = 11;
  localparam int          BEACON_BIT     = 10;
  localparam int          SCALE_LSB      = 8;
  localparam int          MINPWR_LSB     = 0;
  localparam int          N_SEC_CLK      = 7;
  localparam int          MASK_LSB       = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic        PF_DIS_RST     = 1'b0;
  localparam logic [2:0]  L0S_RST        = 3'h6;
  localparam logic [2:0]  L1_RST         = 3'h6;
  localparam logic        VC_EN_RST      = 1'b0;
  localparam logic        CLK_STOP_RST   = 1'b0;
  localparam logic        BEACON_RST     = 1'b0;
  localparam logic [1:0]  SCALE_RST      = 2'h0;
  localparam logic [7:0]  MINPWR_RST     = 8'h00;
  localparam logic [6:0]  CLK_DIS_RST    = 7'h00;
  localparam logic [6:0]  CLK_MASK_RST   = 7'h00;

  // ****************************************************************
  // Behaviour constants
  // ****************************************************************
  localparam logic [2:0]  OVRD_CLK_MASK  = 3'h2;
  localparam logic [2:0]  OVRD_CLK_PIN   = 3'h3;
  localparam logic [3:0]  LINE_DWORDS    = 4'h8;
  localparam logic [3:0]  ONE_DWORD      = 4'h1;
  localparam int          SYNC_STAGES    = 3;
endpackage

// ---- src/bridge_power_clock_control_regs.sv ----
module bridge_power_clock_control_regs
  import bridge_pcc_pkg::*;
(
  input  wire logic        ref_clk,                // 100 MHz clock
  input  wire logic        srst,                   // Power-on reset
  input  wire logic        perst_n,                // Link reset pin
  input  wire logic        global_reset_in,        // Global reset pin
  input  wire logic        cfg_wr,                 // Config write strobe
  input  wire logic        cfg_rd,                 // Config read strobe
  input  wire logic [11:0] cfg_addr,               // Dword byte address
  input  wire logic [3:0]  cfg_be,                 // Byte enables
  input  wire logic [31:0] cfg_wdata,              // Write data
  output logic      [31:0] cfg_rdata,              // Read data
  output logic             cfg_rvalid,             // Read data valid
  input  wire logic        in_d3,                  // Device in D3
  input  wire logic        slot_power_exceeded,    // Slot limit exceeded
  input  wire logic [2:0]  slot_power_response,    // Override field
  input  wire logic        l2_wake_req,            // Wake needed from L2
  input  wire logic        burst_rd_start,         // Burst read begins
  input  wire logic [2:0]  burst_dw_offset,        // Dword within line
  output logic             single_dword_read,      // Prefetch disabled
  output logic      [3:0]  fetch_dwords,           // Dwords to fetch
  output logic      [2:0]  cap_short_idle_exit,    // Capability field
  output logic      [2:0]  cap_deep_idle_exit,     // Capability field
  output logic      [11:0] aer_next_cap,           // Next cap offset
  output logic             wake_assert,            // Drive wake
  output logic             beacon_assert,          // Send beacon
  output logic      [7:0]  min_power_value,        // Min power value
  output logic      [1:0]  min_power_scale,        // Min power scale
  output logic      [6:0]  secondary_clock_output  // Clock run enables
);

  // ****************************************************************
  // Reset pin synchronisers
  // ****************************************************************
  logic [1:0] pin_raw;
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_s3_r;
  logic [1:0] pin_filt_r;
  logic       soft_rst;

  assign pin_raw = {global_reset_in, ~perst_n};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          pin_s1_r[g]   <= 1'b0;
          pin_s2_r[g]   <= 1'b0;
          pin_s3_r[g]   <= 1'b0;
          pin_filt_r[g] <= 1'b0;
        end else begin
          pin_s1_r[g] <= pin_raw[g];
          pin_s2_r[g] <= pin_s1_r[g];
          pin_s3_r[g] <= pin_s2_r[g];
          if (pin_s2_r[g] == pin_s3_r[g]) begin
            pin_filt_r[g] <= pin_s3_r[g];
          end
        end
      end
    end
  endgenerate

  assign soft_rst = |pin_filt_r;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic       wr_gc;
  logic       wr_cc;
  logic       pf_dis_r;
  logic [2:0] l0s_r;
  logic [2:0] l1_r;
  logic       vc_en_r;
  logic       clk_stop_r;
  logic       beacon_r;
  logic [1:0] scale_r;
  logic [7:0] minpwr_r;
  logic [6:0] clk_dis_r;
  logic [6:0] clk_mask_r;

  assign wr_gc = cfg_wr && !soft_rst && (cfg_addr == GEN_CTRL_OFF);
  assign wr_cc = cfg_wr && !soft_rst && (cfg_addr == CLK_CTRL_OFF);

  // Non-sticky fields: every reset source clears them
  always_ff @(posedge ref_clk) begin
    if (srst || soft_rst) begin
      pf_dis_r <= PF_DIS_RST;
      l0s_r    <= L0S_RST;
      l1_r     <= L1_RST;
      vc_en_r  <= VC_EN_RST;
      scale_r  <= SCALE_RST;
      minpwr_r <= MINPWR_RST;
    end else if (wr_gc) begin
      if (cfg_be[0]) begin
        minpwr_r <= cfg_wdata[MINPWR_LSB +: 8];
      end
      if (cfg_be[1]) begin
        scale_r <= cfg_wdata[SCALE_LSB +: 2];
        vc_en_r <= cfg_wdata[VC_EN_BIT];
        l1_r    <= cfg_wdata[L1_LSB +: 3];
      end
      if (cfg_be[2]) begin
        l0s_r    <= cfg_wdata[L0S_LSB +: 3];
        pf_dis_r <= cfg_wdata[PF_DIS_BIT];
      end
    end
  end

  // Sticky fields survive link and global resets
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      clk_stop_r <= CLK_STOP_RST;
      beacon_r   <= BEACON_RST;
    end else if (wr_gc && cfg_be[1]) begin
      clk_stop_r <= cfg_wdata[CLK_STOP_BIT];
      beacon_r   <= cfg_wdata[BEACON_BIT];
    end
  end

  // Clock disable byte and override mask byte
  always_ff @(posedge ref_clk) begin
    if (srst || soft_rst) begin
      clk_dis_r  <= CLK_DIS_RST;
      clk_mask_r <= CLK_MASK_RST;
    end else if (wr_cc) begin
      if (cfg_be[0]) begin
        clk_dis_r <= cfg_wdata[N_SEC_CLK-1:0];
      end
      if (cfg_be[1]) begin
        clk_mask_r <= cfg_wdata[MASK_LSB +: N_SEC_CLK];
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [31:0] gc_word;
  logic [31:0] cc_word;

  assign gc_word = {12'h000, pf_dis_r, l0s_r, l1_r, vc_en_r,
                    clk_stop_r, beacon_r, scale_r, minpwr_r};
  assign cc_word = {16'h0000, 1'b0, clk_mask_r, 1'b0, clk_dis_r};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        unique case (cfg_addr)
          GEN_CTRL_OFF: cfg_rdata <= gc_word;
          CLK_CTRL_OFF: cfg_rdata <= cc_word;
          default:      cfg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Fields reflected into other structures
  // ****************************************************************
  assign cap_short_idle_exit = l0s_r;
  assign cap_deep_idle_exit  = l1_r;
  assign aer_next_cap        = vc_en_r ? AER_NEXT_VC : AER_NEXT_NONE;
  assign min_power_value     = minpwr_r;
  assign min_power_scale     = scale_r;
  assign single_dword_read   = pf_dis_r;

  // ****************************************************************
  // Burst read fetch length
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fetch_dwords <= ONE_DWORD;
    end else if (burst_rd_start) begin
      if (pf_dis_r) begin
        fetch_dwords <= ONE_DWORD;
      end else begin
        fetch_dwords <= LINE_DWORDS - {1'b0, burst_dw_offset};
      end
    end
  end

  // ****************************************************************
  // L2 wake signalling
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wake_assert   <= 1'b0;
      beacon_assert <= 1'b0;
    end else begin
      wake_assert   <= l2_wake_req;
      beacon_assert <= l2_wake_req && beacon_r;
    end
  end

  // ****************************************************************
  // Secondary clock gating
  // ****************************************************************
  logic       ovrd_active;
  logic       d3_stop;
  logic [6:0] clk_off;

  assign ovrd_active = slot_power_exceeded &&
                       ((slot_power_response == OVRD_CLK_MASK) ||
                        (slot_power_response == OVRD_CLK_PIN));
  assign d3_stop     = in_d3 && clk_stop_r;
  assign clk_off     = clk_dis_r | (clk_mask_r & {N_SEC_CLK{ovrd_active}})
                       | {N_SEC_CLK{d3_stop}};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      secondary_clock_output <= 7'h7F;
    end else begin
      secondary_clock_output <= ~clk_off;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_gc_write_lane2;
    wr_gc && cfg_be[2];
  endsequence

  sequence s_gc_write_lane1;
    wr_gc && cfg_be[1];
  endsequence

  sequence s_perst_held;
    !perst_n [*4];
  endsequence

  a_short_idle_mirror: assert property (
    @(posedge ref_clk) disable iff (srst || soft_rst)
    s_gc_write_lane2 |=> cap_short_idle_exit == $past(cfg_wdata[18:16]))
    else $error("short idle capability not mirrored");

  a_deep_idle_mirror: assert property (
    @(posedge ref_clk) disable iff (srst || soft_rst)
    s_gc_write_lane1 |=> cap_deep_idle_exit == $past(cfg_wdata[15:13]))
    else $error("deep idle capability not mirrored");

  a_next_cap_select: assert property (
    @(posedge ref_clk) disable iff (srst || soft_rst)
    s_gc_write_lane1 |=>
      aer_next_cap == ($past(cfg_wdata[12]) ? 12'h150 : 12'h000))
    else $error("next capability offset wrong");

  a_fetch_length: assert property (
    @(posedge ref_clk) disable iff (srst)
    burst_rd_start |=> fetch_dwords ==
      ($past(pf_dis_r) ? 4'h1 : 4'h8 - {1'b0, $past(burst_dw_offset)}))
    else $error("burst fetch length wrong");

  a_disable_stops_clock: assert property (
    @(posedge ref_clk) disable iff (srst || soft_rst)
    wr_cc && cfg_be[0] && cfg_wdata[6] |-> ##2 !secondary_clock_output[6])
    else $error("disabled clock output still running");

  a_d3_stop_clocks: assert property (
    @(posedge ref_clk) disable iff (srst)
    in_d3 && clk_stop_r |=> secondary_clock_output == 7'h00)
    else $error("clocks running in D3 with stop enabled");

  a_mask_override: assert property (
    @(posedge ref_clk) disable iff (srst)
    !ovrd_active && !d3_stop |=> secondary_clock_output == ~$past(clk_dis_r))
    else $error("mask acted without override condition");

  a_reserved_zero: assert property (
    @(posedge ref_clk) disable iff (srst)
    cfg_rvalid && $past(cfg_addr) == 12'h0D8 |-> !cfg_rdata[7] && !cfg_rdata[15])
    else $error("reserved clock bit read nonzero");

  a_wake_method: assert property (
    @(posedge ref_clk) disable iff (srst)
    l2_wake_req |=> wake_assert && (beacon_assert == $past(beacon_r)))
    else $error("wake method does not follow beacon select");

  a_link_reset_defaults: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_perst_held |-> ##2 (l0s_r == L0S_RST && l1_r == L1_RST && minpwr_r == MINPWR_RST
                          && clk_dis_r == CLK_DIS_RST))
    else $error("link reset did not restore defaults");

  a_sticky_hold: assert property (
    @(posedge ref_clk) disable iff (srst)
    soft_rst |=> $stable(clk_stop_r) && $stable(beacon_r))
    else $error("sticky bit lost during link reset");

endmodule

// ---- test/cfg_host_model.sv ----
module cfg_host_model (
  input  wire logic        ref_clk,    // Clock
  input  wire logic [31:0] cfg_rdata,  // Read data
  input  wire logic        cfg_rvalid, // Read valid
  output logic             cfg_wr,     // Write strobe
  output logic             cfg_rd,     // Read strobe
  output logic      [11:0] cfg_addr,   // Address
  output logic      [3:0]  cfg_be,     // Byte enables
  output logic      [31:0] cfg_wdata   // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Config requests, launched on falling edge
  // ****************************************
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 12'hFFF;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end
  task automatic wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge ref_clk);
    cfg_addr = a;
    cfg_be = b;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
    cfg_addr = ~a;
    cfg_be = ~b;
    cfg_wdata = ~d;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic v);
    @(negedge ref_clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    cfg_addr = ~a;
    v = cfg_rvalid;
    d = cfg_rdata;
  endtask
endmodule

// ---- test/tb.sv ----
module tb
  import bridge_pcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, srst = 1'b1, perst_n = 1'b1, global_reset_in = 1'b0;
  logic in_d3 = 1'b0, slot_power_exceeded = 1'b0, l2_wake_req = 1'b0, burst_rd_start = 1'b0;
  logic [2:0] slot_power_response = 3'h0, burst_dw_offset = 3'h0;
  logic cfg_wr, cfg_rd, cfg_rvalid, single_dword_read, wake_assert, beacon_assert;
  logic [11:0] cfg_addr, aer_next_cap;
  logic [3:0] cfg_be, fetch_dwords;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [2:0] cap_short_idle_exit, cap_deep_idle_exit;
  logic [7:0] min_power_value;
  logic [1:0] min_power_scale;
  logic [6:0] secondary_clock_output;
  int fails = 0, check_count = 0;
  always #5 ref_clk = ~ref_clk;
  cfg_host_model cfg_host_model_i (.ref_clk, .cfg_rdata, .cfg_rvalid, .cfg_wr, .cfg_rd,
    .cfg_addr, .cfg_be, .cfg_wdata);
  bridge_power_clock_control_regs bridge_power_clock_control_regs_i (.ref_clk, .srst,
    .perst_n, .global_reset_in, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_rdata, .cfg_rvalid, .in_d3, .slot_power_exceeded, .slot_power_response,
    .l2_wake_req, .burst_rd_start, .burst_dw_offset, .single_dword_read, .fetch_dwords,
    .cap_short_idle_exit, .cap_deep_idle_exit, .aer_next_cap, .wake_assert, .beacon_assert,
    .min_power_value, .min_power_scale, .secondary_clock_output);
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic v;
    cfg_host_model_i.rd(a, d, v);
    chk({31'h0, v}, 32'h1);
    chk(d, e);
  endtask
  task automatic wrs(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    cfg_host_model_i.wr(a, b, d);
    step(2);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values();
    rdc(GEN_CTRL_OFF, 32'h0006C000);
    rdc(CLK_CTRL_OFF, 32'h0);
    chk({25'h0, secondary_clock_output}, 32'h7F);
    chk({20'h0, aer_next_cap}, 32'h0);
    wrs(12'h0DC, 4'hF, 32'hFFFFFFFF);
    rdc(12'h0DC, 32'h0);
  endtask
  task automatic t_fields();
    logic [31:0] w;
    for (int i = 0; i < 8; i++) begin
      w = {12'h0, 1'b0, 3'(i), ~3'(i), i[0], 2'h0, i[1:0], 8'(8'h5A + i)};
      wrs(GEN_CTRL_OFF, 4'hF, w | 32'hFFF00000);
      rdc(GEN_CTRL_OFF, w);
      chk({29'h0, cap_short_idle_exit}, 32'(i));
      chk({29'h0, cap_deep_idle_exit}, {29'h0, ~3'(i)});
      chk({20'h0, aer_next_cap}, i[0] ? 32'h150 : 32'h0);
      chk({30'h0, min_power_scale}, 32'(i[1:0]));
      chk({24'h0, min_power_value}, w[7:0]);
    end
  endtask
  task automatic t_prefetch();
    for (int p = 0; p < 2; p++) begin
      wrs(GEN_CTRL_OFF, 4'h4, p ? 32'h00080000 : 32'h0);
      chk({31'h0, single_dword_read}, 32'(p));
      for (int o = 0; o < 8; o += 7) begin
        burst_dw_offset = 3'(o);
        burst_rd_start = 1'b1;
        step(1);
        burst_rd_start = 1'b0;
        step(1);
        chk({28'h0, fetch_dwords}, p ? 32'h1 : 32'(8 - o));
      end
    end
  endtask
  task automatic t_clocks();
    wrs(CLK_CTRL_OFF, 4'h1, 32'hFF);
    rdc(CLK_CTRL_OFF, 32'h7F);
    chk({25'h0, secondary_clock_output}, 32'h0);
    wrs(CLK_CTRL_OFF, 4'h1, 32'h40);
    chk({25'h0, secondary_clock_output}, 32'h3F);
    wrs(CLK_CTRL_OFF, 4'h3, 32'h0500);
    rdc(CLK_CTRL_OFF, 32'h0500);
    slot_power_exceeded = 1'b1;
    for (int r = 0; r < 8; r++) begin
      slot_power_response = 3'(r);
      step(2);
      chk({25'h0, secondary_clock_output}, (r == 2 || r == 3) ? 32'h7A : 32'h7F);
    end
    slot_power_response = 3'h2;
    slot_power_exceeded = 1'b0;
    step(2);
    chk({25'h0, secondary_clock_output}, 32'h7F);
    in_d3 = 1'b1;
    step(2);
    chk({25'h0, secondary_clock_output}, 32'h7F);
    wrs(GEN_CTRL_OFF, 4'h2, 32'h0800);
    chk({25'h0, secondary_clock_output}, 32'h0);
    in_d3 = 1'b0;
    step(2);
    chk({25'h0, secondary_clock_output}, 32'h7F);
  endtask
  task automatic t_wake();
    l2_wake_req = 1'b1;
    step(2);
    chk({30'h0, wake_assert, beacon_assert}, 32'h2);
    wrs(GEN_CTRL_OFF, 4'h2, 32'h0C00);
    chk({30'h0, wake_assert, beacon_assert}, 32'h3);
    l2_wake_req = 1'b0;
    step(2);
    chk({30'h0, wake_assert, beacon_assert}, 32'h0);
  endtask
  task automatic t_resets();
    for (int k = 0; k < 2; k++) begin
      wrs(CLK_CTRL_OFF, 4'h3, 32'h0505);
      if (k) global_reset_in = 1'b1;
      else perst_n = 1'b0;
      step(8);
      wrs(CLK_CTRL_OFF, 4'h1, 32'h11);
      perst_n = 1'b1;
      global_reset_in = 1'b0;
      step(10);
      rdc(GEN_CTRL_OFF, 32'h0006CC00);
      rdc(CLK_CTRL_OFF, 32'h0);
    end
    srst = 1'b1;
    step(2);
    srst = 1'b0;
    rdc(GEN_CTRL_OFF, 32'h0006C000);
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    step(20);
    srst = 1'b0;
    t_reset_values();
    t_fields();
    t_prefetch();
    t_clocks();
    t_wake();
    t_resets();
    close_out();
  end
endmodule
